// ### cpe_cfg_master.sv
// configuration master model: completion pin, strobes, serial bits
// assumes the bench changes its commands at the falling clock edge
`timescale 1ns/100ps
module cpe_cfg_master (
   input  wire logic              hold_i,
   input  wire logic [3:0]        strb_i,
   input  wire logic              bit_i,
   input  wire logic              done_oe_i,
   output logic                   setup_complete_o,
   output cpe_pkg::cpe_host_strb_t strb_o,
   output logic                   serial_o
);
   // pulled-up wire, low when either side pulls
   assign setup_complete_o = !(hold_i || done_oe_i);
   assign strb_o = strb_i;
   assign serial_o = bit_i;
endmodule : cpe_cfg_master

// ### cpe_config_pins.sv
// Overview of operation
// R01 - setup clock pin is input only
// R02 - pulled-up completion pin low enables setup pins
// R03 - reset or reprogram low resets device
// R04 - readback trigger and readback line ignored
// R05 - scan inputs pulled up during setup
// R06 - handshake flag, high-during-setup high in setup
// R07 - open-drain phase flag reads high in setup
// R08 - low-during-setup driven low in setup
// R09 - slave serial bits passed after fixed delay
// R10 - pass output inactive outside slave serial
// R11 - mode select inputs have no effect
// R12 - peripheral read puts flag on bit 7
// R13 - byte bus pulled up during setup
// R14 - undefined setup pins have no function
// R15 - global clock pins are ordinary inputs
// R16 - no register preload from output pins
// R17 - completion asserted right after power-up
// R18 - completion not cleared by reset by default
// R19 - completion high: pins are user pins
//
// top of the configuration pin emulation logic
// assumes clk_i at 40 MHz; pins arrive asynchronous and are synchronised
`timescale 1ns/100ps
`include "cpe_params.svh"
module cpe_config_pins #(
   parameter int unsigned BUS_WIDTH       = `CPE_BUS_WIDTH,
   parameter bit          DONE_RESET_OPT  = 1'b0,
   parameter bit          SLAVE_SERIAL    = `CPE_MODE_SLAVE_SERIAL
) (
   input  wire logic                  clk_i,
   input  wire logic                  rstn_i,
   input  wire logic                  reprogram_n_i,
   input  wire logic                  setup_clock_i,
   input  wire logic                  setup_complete_i,
   output logic                       setup_complete_o,
   output logic                       setup_complete_oe_o,
   output logic                       setup_complete_pu_o,
   input  wire logic                  mode_zero_readback_trigger_i,
   input  wire logic                  mode_one_readback_line_i,
   input  wire logic                  mode_sel_zero_i,
   input  wire logic                  mode_sel_one_i,
   input  wire logic                  mode_sel_two_i,
   input  wire logic                  serial_cfg_in_i,
   output logic                       serial_cfg_pass_out_o,
   output logic                       serial_cfg_pass_oe_o,
   input  wire cpe_pkg::cpe_host_strb_t host_strb_i,
   input  wire logic [BUS_WIDTH-1:0]  host_byte_bus_i,
   output logic      [BUS_WIDTH-1:0]  host_byte_bus_o,
   output logic      [BUS_WIDTH-1:0]  host_byte_bus_oe_o,
   output logic      [BUS_WIDTH-1:0]  host_byte_bus_pu_o,
   output logic                       host_handshake_flag_o,
   output logic                       high_during_setup_o,
   output logic                       low_during_setup_o,
   output logic                       setup_phase_flag_o,
   output logic                       setup_phase_flag_oe_o,
   output logic                       setup_phase_flag_pu_o,
   input  wire cpe_pkg::cpe_scan_t    scan_i,
   output logic                       scan_pu_o,
   output logic                       user_mode_o,
   output logic                       device_reset_o
);
   localparam int unsigned PASS_CYC_RAW =
      (`CPE_PASS_DELAY_NS + `CPE_CLK_PERIOD_NS - 1) / `CPE_CLK_PERIOD_NS;
   // two sync flops and the output flop add to the line;
   // limitation: pass latency is never below four cycles
   localparam int unsigned PASS_CYC = (PASS_CYC_RAW < 4) ? 1
                                      : PASS_CYC_RAW - 3;

   if (BUS_WIDTH <= `CPE_FLAG_BIT) begin : g_bad_width
      $error("cpe_config_pins: BUS_WIDTH must cover the flag bit");
   end

   // two-flop synchronisers; stage one read only by stage two
   localparam int unsigned NSYNC = 7;
   logic [NSYNC-1:0] raw_w;
   logic [NSYNC-1:0] sync1_q;
   logic [NSYNC-1:0] sync2_q;
   assign raw_w = {reprogram_n_i, setup_complete_i, serial_cfg_in_i,
                   host_strb_i.select_low_n, host_strb_i.select_high,
                   host_strb_i.read_strobe_n, host_strb_i.store_strobe_n};

   genvar s;
   generate
      for (s = 0; s < NSYNC; s++) begin : g_sync
         always_ff @(posedge clk_i) begin
            if (!rstn_i) begin
               sync1_q[s] <= 1'b1;
               sync2_q[s] <= 1'b1;
            end else begin
               sync1_q[s] <= raw_w[s];
               sync2_q[s] <= sync1_q[s];
            end
         end
      end
   endgenerate

   wire reprog_n_s  = sync2_q[6];
   wire done_pin_s  = sync2_q[5];
   wire din_s       = sync2_q[4];
   wire cs_lo_n_s   = sync2_q[3];
   wire cs_hi_s     = sync2_q[2];
   wire rd_n_s      = sync2_q[1];
   wire wr_n_s      = sync2_q[0];

   // reprogram clears the pass and bus flops too, not the synchronisers
   wire rst_all_n_w = rstn_i && reprog_n_s; // [R03]

   // reset pins reset the device logic [R03]
   assign device_reset_o = !rstn_i || !reprog_n_s; // [R03]

   // completion: high from power-up, no config data awaited [R17]
   // only the reset option may clear it [R18]
   logic done_q;
   logic done_d;
   assign done_d = (DONE_RESET_OPT && !reprog_n_s) ? 1'b0 : 1'b1; // [R18]
   always_ff @(posedge clk_i) begin
      if (!rstn_i && DONE_RESET_OPT) begin
         done_q <= 1'b0; // [R18]
      end else begin
         done_q <= done_d; // [R17]
      end
   end

   // pin is pulled up; outside world may hold it low [R02]
   // released driver: open-drain low only while reset option active
   assign setup_complete_o    = 1'b0;
   assign setup_complete_oe_o = !done_q; // [R02]
   assign setup_complete_pu_o = 1'b1;    // [R02]

   // setup mode exists only while the pin is seen low [R02] [R19]
   wire in_setup_w = !done_pin_s;
   assign user_mode_o = !in_setup_w; // [R19]

   // status outputs follow the completion pin [R06] [R07] [R08]
   assign host_handshake_flag_o = in_setup_w; // [R06]
   assign high_during_setup_o   = in_setup_w; // [R06]
   assign low_during_setup_o    = !in_setup_w; // [R08]

   // open-drain: released in setup so pull-up reads high [R07]
   assign setup_phase_flag_o    = 1'b0;
   assign setup_phase_flag_oe_o = 1'b0; // [R07]
   assign setup_phase_flag_pu_o = 1'b1; // [R07]

   // scan inputs pulled up only during setup [R05]
   assign scan_pu_o = in_setup_w; // [R05]

   // serial pass-through; bits never absorbed [R09]
   logic pass_w;
   cpe_pass_line #(
      .DEPTH (PASS_CYC)
   ) u_pass (
      .clk_i  (clk_i),
      .rstn_i (rst_all_n_w),
      .data_i (din_s),
      .data_o (pass_w)
   );

   // the pass output drives only in slave serial setup [R10]
   logic pass_q;
   logic pass_oe_q;
   wire  pass_en_w = SLAVE_SERIAL && in_setup_w; // [R10]
   always_ff @(posedge clk_i) begin
      if (!rst_all_n_w) begin
         pass_q    <= 1'b0;
         pass_oe_q <= 1'b0;
      end else begin
         pass_q    <= pass_en_w ? pass_w : 1'b0; // [R09]
         pass_oe_q <= pass_en_w; // [R10]
      end
   end
   assign serial_cfg_pass_out_o = pass_q;
   assign serial_cfg_pass_oe_o  = pass_oe_q;

   // peripheral status read puts the flag on bus bit 7 [R12]
   wire status_rd_w = in_setup_w && !cs_lo_n_s && !rd_n_s
                      && wr_n_s && cs_hi_s; // [R12]
   logic [BUS_WIDTH-1:0] bus_q;
   logic [BUS_WIDTH-1:0] bus_oe_q;
   always_ff @(posedge clk_i) begin
      if (!rst_all_n_w) begin
         bus_q    <= '0;
         bus_oe_q <= '0;
      end else begin
         bus_q    <= '0;
         bus_oe_q <= '0;
         if (status_rd_w) begin
            bus_q[`CPE_FLAG_BIT]    <= host_handshake_flag_o; // [R12]
            bus_oe_q[`CPE_FLAG_BIT] <= 1'b1; // [R12]
         end
      end
   end
   assign host_byte_bus_o    = bus_q;
   assign host_byte_bus_oe_o = bus_oe_q;

   // pull-ups on every bus line during setup [R13]
   assign host_byte_bus_pu_o = {BUS_WIDTH{in_setup_w}}; // [R13]

   // ignored inputs: clock, readback, mode selects, bus data, scan.
   // kept unread on purpose; levels cannot change behaviour
   // setup clock is input only, never driven [R01]
   // readback pins ignored, no contents to return [R04]
   // mode selects have no effect [R11]
   // other setup pins carry no function [R14]
   // global clocks are plain user inputs [R15]
   // no register preload path exists [R16]
endmodule : cpe_config_pins

// ### cpe_config_pins_sva.sv
// assertions on the configuration pin emulation top
// assumes one clk_i domain with synchronous rstn_i
`timescale 1ns/100ps
module cpe_config_pins_sva #(
   parameter int unsigned BUS_WIDTH = 8
) (
   input wire logic                   clk_i,
   input wire logic                   rstn_i,
   input wire logic                   reprogram_n_i,
   input wire logic                   setup_complete_i,
   input wire logic                   setup_complete_oe_o,
   input wire logic                   serial_cfg_in_i,
   input wire logic                   serial_cfg_pass_out_o,
   input wire logic                   serial_cfg_pass_oe_o,
   input wire cpe_pkg::cpe_host_strb_t host_strb_i,
   input wire logic [BUS_WIDTH-1:0]   host_byte_bus_o,
   input wire logic [BUS_WIDTH-1:0]   host_byte_bus_oe_o,
   input wire logic [BUS_WIDTH-1:0]   host_byte_bus_pu_o,
   input wire logic                   host_handshake_flag_o,
   input wire logic                   high_during_setup_o,
   input wire logic                   low_during_setup_o,
   input wire logic                   device_reset_o
);
   logic [2:0] age_q;
   logic       ok;
   logic       rd;
   // $past needs history from after reset
   assign ok = (age_q == 3'h7);
   assign rd = !host_strb_i.select_low_n && host_strb_i.select_high &&
      !host_strb_i.read_strobe_n && host_strb_i.store_strobe_n &&
      !setup_complete_i && reprogram_n_i;
   always_ff @(posedge clk_i) begin
      if (!rstn_i) age_q <= 3'h0;
      else if (!ok) age_q <= age_q + 3'h1;
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rstn_i);
   a_flag_in_setup:
      assert property (ok |-> host_handshake_flag_o ==
         !$past(setup_complete_i, 2)) else $error("handshake flag wrong");
   a_high_in_setup:
      assert property (ok |-> high_during_setup_o ==
         !$past(setup_complete_i, 2)) else $error("high flag wrong");
   a_low_in_setup:
      assert property (ok |-> low_during_setup_o ==
         $past(setup_complete_i, 2)) else $error("low flag wrong");
   a_bus_pull_up:
      assert property (ok |-> host_byte_bus_pu_o ==
         {BUS_WIDTH{!$past(setup_complete_i, 2)}})
         else $error("pull-up wrong");
   a_pass_delay:
      assert property (ok && serial_cfg_pass_oe_o &&
         $past(serial_cfg_pass_oe_o) && $past(serial_cfg_pass_oe_o, 4)
         |-> serial_cfg_pass_out_o == $past(serial_cfg_in_i, 4))
         else $error("pass bit wrong");
   a_pass_quiet:
      assert property (ok && $past(setup_complete_i, 3) |->
         !serial_cfg_pass_oe_o && !serial_cfg_pass_out_o)
         else $error("pass output active outside setup");
   a_status_read:
      assert property (ok && rd [*4] |-> host_byte_bus_oe_o[7] &&
         host_byte_bus_o[7]) else $error("status bit missing");
   a_done_not_driven:
      assert property (!setup_complete_oe_o) else $error("completion driven");
   a_reprogram_reset:
      assert property ((!reprogram_n_i) [*3] |-> device_reset_o)
         else $error("reprogram did not reset");
   c_read: cover property (rd [*4]);
   c_pass: cover property (ok && serial_cfg_pass_oe_o);
   c_reprog: cover property ((!reprogram_n_i) [*3]);
endmodule : cpe_config_pins_sva
bind cpe_config_pins cpe_config_pins_sva #(.BUS_WIDTH(BUS_WIDTH))
   u_cpe_config_pins_sva (.clk_i(clk_i), .rstn_i(rstn_i),
   .reprogram_n_i(reprogram_n_i), .setup_complete_i(setup_complete_i),
   .setup_complete_oe_o(setup_complete_oe_o),
   .serial_cfg_in_i(serial_cfg_in_i),
   .serial_cfg_pass_out_o(serial_cfg_pass_out_o),
   .serial_cfg_pass_oe_o(serial_cfg_pass_oe_o), .host_strb_i(host_strb_i),
   .host_byte_bus_o(host_byte_bus_o), .host_byte_bus_oe_o(host_byte_bus_oe_o),
   .host_byte_bus_pu_o(host_byte_bus_pu_o),
   .host_handshake_flag_o(host_handshake_flag_o),
   .high_during_setup_o(high_during_setup_o),
   .low_during_setup_o(low_during_setup_o), .device_reset_o(device_reset_o));

// ### cpe_params.svh
// constants for the configuration pin emulation block
// assumes inclusion by bare name from the design files
`ifndef CPE_PARAMS_SVH
`define CPE_PARAMS_SVH
`define CPE_PASS_DELAY_NS     50
`define CPE_CLK_PERIOD_NS     25
`define CPE_BUS_WIDTH         8
`define CPE_FLAG_BIT          7
`define CPE_DONE_RESET_VAL    1'b1
`define CPE_MODE_SLAVE_SERIAL 1'b1
`endif

// ### cpe_pass_line.sv
// delay line for the serial pass-through path
// assumes its input is already synchronised to clk_i
`timescale 1ns/100ps
module cpe_pass_line #(
   parameter int unsigned DEPTH = 2
) (
   input  wire logic clk_i,
   input  wire logic rstn_i,
   input  wire logic data_i,
   output logic      data_o
);
   logic [DEPTH-1:0] shift_q;

   if (DEPTH < 1) begin : g_bad_depth
      $error("cpe_pass_line: DEPTH must be at least one");
   end

   // one flop per stage; fixed latency, nothing absorbed
   genvar g;
   generate
      for (g = 0; g < DEPTH; g++) begin : g_stage
         always_ff @(posedge clk_i) begin
            if (!rstn_i) begin
               shift_q[g] <= 1'b0;
            end else begin
               shift_q[g] <= (g == 0) ? data_i : shift_q[(g == 0) ? 0 : g-1];
            end
         end
      end
   endgenerate

   assign data_o = shift_q[DEPTH-1];
endmodule : cpe_pass_line

// ### cpe_pkg.sv
// types shared by the configuration pin emulation block
// assumes no surroundings beyond the params header
package cpe_pkg;
   typedef struct packed {
      logic select_low_n;
      logic select_high;
      logic read_strobe_n;
      logic store_strobe_n;
   } cpe_host_strb_t;

   typedef struct packed {
      logic test_data_in;
      logic test_clock;
      logic test_mode_select;
   } cpe_scan_t;

   typedef enum logic [1:0] {
      CPE_ST_USER  = 2'b00,
      CPE_ST_SETUP = 2'b01
   } cpe_state_t;
endpackage : cpe_pkg

// ### test_cpe_config_pins.sv
// self-checking bench for the configuration pin emulation top
// assumes the bound checker and the master model beside it
`timescale 1ns/100ps
module test_cpe_config_pins;
   logic clk_i = 1'b0, rstn_i = 1'b0, rp_n = 1'b1, hold = 1'b0, din = 1'b0;
   logic [3:0] strb = 4'hA;
   logic [5:0] ign = 6'h00;
   logic [7:0] bus_i = 8'h00, bo, boe, bpu, pat = 8'hB4;
   cpe_pkg::cpe_host_strb_t hs;
   cpe_pkg::cpe_scan_t scan = 3'h0;
   logic sc, sd, sc_oe, po, poe, hf, hd, ld, pf_oe, pf_pu, spu, um, dr;
   logic scd, scp, pfo;
   int mismatches = 0, total_checks = 0, cyc = 0;
   cpe_config_pins u_cpe_config_pins (.clk_i(clk_i), .rstn_i(rstn_i),
      .reprogram_n_i(rp_n), .setup_clock_i(ign[0]), .setup_complete_i(sc),
      .setup_complete_o(scd), .setup_complete_oe_o(sc_oe),
      .setup_complete_pu_o(scp), .mode_zero_readback_trigger_i(ign[1]),
      .mode_one_readback_line_i(ign[2]), .mode_sel_zero_i(ign[3]),
      .mode_sel_one_i(ign[4]), .mode_sel_two_i(ign[5]),
      .serial_cfg_in_i(sd), .serial_cfg_pass_out_o(po),
      .serial_cfg_pass_oe_o(poe), .host_strb_i(hs), .host_byte_bus_i(bus_i),
      .host_byte_bus_o(bo), .host_byte_bus_oe_o(boe),
      .host_byte_bus_pu_o(bpu), .host_handshake_flag_o(hf),
      .high_during_setup_o(hd), .low_during_setup_o(ld),
      .setup_phase_flag_o(pfo), .setup_phase_flag_oe_o(pf_oe),
      .setup_phase_flag_pu_o(pf_pu), .scan_i(scan), .scan_pu_o(spu),
      .user_mode_o(um), .device_reset_o(dr));
   cpe_cfg_master u_cpe_cfg_master (.hold_i(hold), .strb_i(strb),
      .bit_i(din), .done_oe_i(sc_oe), .setup_complete_o(sc), .strb_o(hs),
      .serial_o(sd));
   initial forever #12.5 clk_i = ~clk_i;
   task automatic conclude;
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : conclude
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic wn(input int n);
      repeat (n) @(negedge clk_i);
   endtask : wn
   task automatic t_user;
      chk({1'b0, hf, hd, ld, um, poe, sc_oe, spu}, 8'h18);
      chk({5'h00, scd, scp, sc_oe}, 8'h02);
   endtask : t_user
   task automatic t_setup;
      hold = 1'b1;
      wn(2);
      chk({hf, hd, ld, um, spu, 3'h0}, 8'hC8);
      chk({pf_oe, pf_pu, pfo, 5'h00}, 8'h40);
      chk(bpu, 8'hFF);
   endtask : t_setup
   task automatic t_ignored;
      ign = 6'h3F;
      scan = 3'h7;
      bus_i = 8'hFF;
      wn(4);
      chk({hf, hd, ld, um, boe[3:0]}, 8'hC0);
      chk(bo, 8'h00);
      ign = 6'h00;
   endtask : t_ignored
   task automatic t_read;
      strb = 4'h5;
      wn(3);
      chk(boe, 8'h80);
      chk({7'h00, bo[7]}, 8'h01);
      // one wrong strobe at a time must not put the flag out
      for (int i = 0; i < 4; i++) begin
         strb = 4'h5 ^ (4'h1 << i);
         wn(3);
         chk(boe, 8'h00);
      end
      strb = 4'hA;
   endtask : t_read
   task automatic t_serial;
      for (int i = 0; i < 12; i++) begin
         if (i >= 4) chk({poe, po}, {1'b1, pat[i-4]});
         din = pat[i%8];
         wn(1);
      end
   endtask : t_serial
   task automatic t_release;
      hold = 1'b0;
      wn(2);
      chk({hf, hd, ld, um, bpu[3:0]}, 8'h30);
      wn(2);
      chk({7'h00, poe}, 8'h00);
   endtask : t_release
   task automatic t_reset;
      rp_n = 1'b0;
      wn(3);
      chk({6'h00, dr, sc_oe}, 8'h02);
      rp_n = 1'b1;
      wn(3);
      chk({7'h00, dr}, 8'h00);
      rstn_i = 1'b0;
      wn(3);
      chk({7'h00, dr}, 8'h01);
      rstn_i = 1'b1;
      wn(3);
      chk({5'h00, dr, um, sc}, 8'h03);
   endtask : t_reset
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 2000) begin
         mismatches++;
         $display("MISMATCH at %0t: run too long", $time);
         conclude();
      end
   end
   initial begin
      wn(2);
      rstn_i = 1'b1;
      wn(8);
      t_user();
      t_setup();
      t_ignored();
      t_read();
      t_serial();
      t_release();
      t_reset();
      conclude();
   end
endmodule : test_cpe_config_pins
